// >>> viu_regs.svh
// viu_regs.svh: register indices, field positions, reset values and vector
// addresses of the vectored interrupt unit.
// assumes: included by bare name; definitions only.
`ifndef VIU_REGS_SVH
`define VIU_REGS_SVH

`define VIU_NSRC        16
// register indices; the apb byte address is four times the index
`define VIU_IDX_ADC     8'h70
`define VIU_IDX_U0TX    8'h71
`define VIU_IDX_U0RX    8'h72
`define VIU_IDX_U1TX    8'h73
`define VIU_IDX_U1RX    8'h74
`define VIU_IDX_TA0     8'h75
`define VIU_IDX_INT0    8'h7D
`define VIU_IDX_PS      8'h60
`define VIU_IDX_STAT    8'h61
// control register fields
`define VIU_LVL         2:0
`define VIU_REQ         3
`define VIU_TRIG        5:4
`define VIU_CTL_MASK    8'h0F
`define VIU_CTL_MASK_X  8'h3F
`define VIU_CTL_RST     8'h00
`define VIU_TRIG_FALL   2'h0
`define VIU_TRIG_RISE   2'h1
`define VIU_TRIG_HIGH   2'h2
`define VIU_TRIG_LOW    2'h3
// processor status word fields
`define VIU_PS_IFLAG    2
`define VIU_PS_IPL      10:8
`define VIU_PS_RST      16'h0004
// source codes: 0..15 maskable in chain order, then the fixed ones
`define VIU_SRC_TA0     5'h03
`define VIU_SRC_U0RX    5'h0B
`define VIU_SRC_U0TX    5'h0C
`define VIU_SRC_U1RX    5'h0D
`define VIU_SRC_U1TX    5'h0E
`define VIU_SRC_ZDIV    5'h10
`define VIU_SRC_BRK     5'h11
`define VIU_SRC_DBG     5'h12
`define VIU_SRC_WDT     5'h13
`define VIU_SRC_RESET   5'h14
// vector low-byte addresses in bank zero
`define VIU_VEC_RESET   16'hFFFE
`define VIU_VEC_ZDIV    16'hFFFC
`define VIU_VEC_BRK     16'hFFFA
`define VIU_VEC_DBG     16'hFFF8
`define VIU_VEC_WDT     16'hFFF6
`define VIU_VEC_MASK0   16'hFFF4
`define VIU_VEC_LOW     16'hFFD6
`define VIU_BANK0       8'h00
`define VIU_SP_STEP     16'h0001
`define VIU_SP_WSTEP    16'h0002

`endif

// >>> viu_pkg.sv
// viu_pkg: types shared by the vectored interrupt unit.
// assumes: nothing; types only, constants live in viu_regs.svh.
package viu_pkg;

	// sequencer: stack the frame, then fetch the vector
	typedef enum {S_IDLE, S_PG, S_PCH, S_PCL, S_PSH, S_PSL, S_VEC} viu_state_e;

	// context the cpu core offers at an instruction boundary
	typedef struct packed {
		logic [7:0]  pg;
		logic [15:0] pc;
		logic [15:0] sp;
	} viu_ctx_s;

	// frame captured at acceptance
	typedef struct packed {
		logic [7:0]  pg;
		logic [15:0] pc;
		logic [15:0] ps;
	} viu_frame_s;

	// one memory request toward the cpu bus
	typedef struct packed {
		logic        req;
		logic        we;
		logic        word;
		logic [23:0] addr;
		logic [15:0] wdata;
	} viu_mem_s;

	// peripheral event pulses
	typedef struct packed {
		logic [4:0] timer_a;
		logic [2:0] timer_b;
		logic [1:0] rx;
		logic [1:0] tx;
		logic       adc;
	} viu_evt_s;

endpackage

// >>> viu_ext_sense.sv
// viu_ext_sense: edge or level sensing of one external request pin.
// assumes: pin synchronous to core_clk, pulses wider than one clock.
`timescale 1ns/1ps
`include "viu_regs.svh"

module viu_ext_sense (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       pin,
	input  wire logic [1:0] trig,
	output logic            edge_hit,
	output logic            level_req
);

	logic prev_r, prev_nxt;
	logic armed_r, armed_nxt;

	// armed keeps the first sample after reset from looking like an edge
	always_comb begin
		prev_nxt  = pin;
		armed_nxt = 1'b1;
		edge_hit  = 1'b0;
		level_req = 1'b0;
		case (trig)
			`VIU_TRIG_FALL: edge_hit  = armed_r & prev_r & ~pin;
			`VIU_TRIG_RISE: edge_hit  = armed_r & ~prev_r & pin;
			`VIU_TRIG_HIGH: level_req = pin;
			default:        level_req = ~pin;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_r  <= 1'b0;
			armed_r <= 1'b0;
		end else begin
			prev_r  <= prev_nxt;
			armed_r <= armed_nxt;
		end
	end

	chk_fall_edge: assert property (@(posedge core_clk) disable iff (!arst_n)
		(trig == `VIU_TRIG_FALL && armed_r && $fell(pin)) |-> edge_hit)
		else $error("falling edge on pin not reported");

endmodule // viu_ext_sense

// >>> viu_core.sv
// viu_core: vectored interrupt unit with apb control registers.
// assumes: apb master on core_clk; cpu core raises cpu_at_boundary between
// instructions and answers each mem request with a one-cycle mem_ack.
`timescale 1ns/1ps
`include "viu_regs.svh"

// What this block does
// - twenty-one causes, each branching through own vector
// - vector table at top of bank zero
// - two-byte vectors, fixed descending source order
// - stack bank, then counter, then status only
// - even stack pointer word pushes, odd bytewise
// - zero divisor raises non-maskable trap
// - break instruction raises non-maskable trap
// - watchdog msb falling raises non-maskable request
// - each first-group timer raises own request
// - each second-group timer raises own request
// - serial requests only in asynchronous mode
// - converter completion raises its request
// - external pins request by level or edge
// - trigger field bits 5:4 select sensing
// - request bit set, cleared on acceptance
// - level must exceed threshold; zero disables
// - disable flag masks maskables, set at reset
// - level-sensed pins do not latch request
module viu_core import viu_pkg::*; #(
	parameter int NSRC = `VIU_NSRC
) (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire viu_ctx_s    cpu_ctx,
	input  wire logic        cpu_at_boundary,
	input  wire viu_evt_s    evt,
	input  wire logic [1:0]  serial_async,
	input  wire logic [2:0]  external_request_pin,
	input  wire logic        zero_div_trap,
	input  wire logic        software_break_trap,
	input  wire logic        debug_trap,
	input  wire logic        wdt_msb,
	output viu_mem_s         mem,
	input  wire logic        mem_ack,
	input  wire logic [15:0] mem_rdata,
	output logic             vector_taken,
	output logic      [15:0] program_counter_reg,
	output logic      [7:0]  program_bank_reg,
	output logic      [15:0] stack_ptr,
	output logic      [15:0] processor_status_word
);

	// control register index of a maskable source
	function automatic logic [7:0] ctl_idx(input logic [4:0] s);
		logic [7:0] r;
		r = `VIU_IDX_ADC;
		if (s < `VIU_SRC_TA0)
			r = `VIU_IDX_INT0 + {3'h0, s};
		else if (s < `VIU_SRC_U0RX)
			r = `VIU_IDX_TA0 + {3'h0, 5'(s - `VIU_SRC_TA0)};
		else case (s)
			`VIU_SRC_U0RX: r = `VIU_IDX_U0RX;
			`VIU_SRC_U0TX: r = `VIU_IDX_U0TX;
			`VIU_SRC_U1RX: r = `VIU_IDX_U1RX;
			`VIU_SRC_U1TX: r = `VIU_IDX_U1TX;
			default:       r = `VIU_IDX_ADC;
		endcase
		return r;
	endfunction

	// vector low-byte address of any source; high byte sits one above
	function automatic logic [15:0] vec_of(input logic [4:0] s);
		logic [15:0] v;
		v = `VIU_VEC_RESET;
		if (s < `VIU_SRC_ZDIV)
			v = `VIU_VEC_MASK0 - {10'h000, s, 1'b0};
		else case (s)
			`VIU_SRC_ZDIV: v = `VIU_VEC_ZDIV;
			`VIU_SRC_BRK:  v = `VIU_VEC_BRK;
			`VIU_SRC_DBG:  v = `VIU_VEC_DBG;
			`VIU_SRC_WDT:  v = `VIU_VEC_WDT;
			default:       v = `VIU_VEC_RESET;
		endcase
		return v;
	endfunction

	logic [NSRC-1:0][7:0] ctl_r, ctl_nxt;
	logic [15:0]          ps_r, ps_nxt;
	logic [3:0]           nmi_r, nmi_nxt;
	logic                 wdt_prev_r, wdt_prev_nxt;
	viu_state_e           st_r, st_nxt;
	viu_mem_s             mem_r, mem_nxt;
	viu_frame_s           frm_r, frm_nxt;
	logic [15:0]          sp_r, sp_nxt;
	logic                 wide_r, wide_nxt;
	logic [4:0]           src_r, src_nxt;
	logic                 taken_r, taken_nxt;
	logic [15:0]          jpc_r, jpc_nxt;
	logic [7:0]           jpg_r, jpg_nxt;
	logic [31:0]          prdata_r, prdata_nxt;
	logic                 pready_r, pready_nxt;
	logic                 pslverr_r, pslverr_nxt;
	logic [2:0]           ext_edge, ext_level;
	logic [NSRC-1:0]      set_evt, pend, elig;
	logic                 win_ok, acc, acc_nmi, apb_wr, ctl_hit, wdt_fall;
	logic [2:0]           win_lvl;
	logic [4:0]           win_src, acc_src, ctl_src;
	logic [7:0]           idx;

	// external pins; their direction in the shared port is software's job
	for (genvar g = 0; g < 3; g++) begin : g_ext
		viu_ext_sense u_sense (
			.core_clk  (core_clk),
			.arst_n    (arst_n),
			.pin       (external_request_pin[g]),
			.trig      (ctl_r[g][`VIU_TRIG]),
			.edge_hit  (ext_edge[g]),
			.level_req (ext_level[g])
		);
	end

	// peripheral events, serial ones gated by asynchronous mode
	assign set_evt = {evt.adc,
	                  evt.tx[1] & serial_async[1], evt.rx[1] & serial_async[1],
	                  evt.tx[0] & serial_async[0], evt.rx[0] & serial_async[0],
	                  evt.timer_b,
	                  evt.timer_a,
	                  ext_edge};
	assign wdt_fall = wdt_prev_r & ~wdt_msb;

	// apb decode; registers sit one per aligned word
	always_comb begin
		idx     = paddr[9:2];
		ctl_hit = 1'b0;
		ctl_src = 5'h00;
		for (int i = 0; i < NSRC; i++) begin
			if (ctl_idx(5'(i)) == idx) begin
				ctl_hit = 1'b1;
				ctl_src = 5'(i);
			end
		end
	end
	assign apb_wr = psel & penable & pwrite & pready_r & ~pslverr_r;

	// apb answer: data and ready prepared in setup, valid in access phase
	always_comb begin
		pready_nxt  = psel & ~penable;
		pslverr_nxt = 1'b0;
		prdata_nxt  = prdata_r;
		if (psel && !penable) begin
			prdata_nxt  = 32'h0000_0000;
			pslverr_nxt = (paddr[11:10] != 2'h0) || (paddr[1:0] != 2'h0);
			if (idx == `VIU_IDX_PS)
				prdata_nxt = {16'h0000, ps_r};
			else if (idx == `VIU_IDX_STAT)
				prdata_nxt = {22'h000000, st_r != S_IDLE, src_r, nmi_r};
			else if (ctl_hit)
				prdata_nxt = {24'h000000, ctl_r[ctl_src[3:0]]};
			else
				pslverr_nxt = 1'b1;
		end
	end

	// arbitration: upstream source keeps ties, so only a higher level replaces
	always_comb begin
		win_ok  = 1'b0;
		win_lvl = 3'h0;
		win_src = 5'h00;
		for (int i = 0; i < NSRC; i++) begin
			// a level-sensed pin requests straight from the pin
			pend[i] = (i < 3 && ctl_r[i][`VIU_TRIG] >= `VIU_TRIG_HIGH) ?
			          ext_level[i % 3] : ctl_r[i][`VIU_REQ];
			elig[i] = pend[i] && !ps_r[`VIU_PS_IFLAG] &&
			          ctl_r[i][`VIU_LVL] > ps_r[`VIU_PS_IPL];
			if (elig[i] && ctl_r[i][`VIU_LVL] > win_lvl) begin
				win_ok  = 1'b1;
				win_lvl = ctl_r[i][`VIU_LVL];
				win_src = 5'(i);
			end
		end
		acc_nmi = |nmi_r;
		acc_src = win_src;
		if (nmi_r[0])      acc_src = `VIU_SRC_ZDIV;
		else if (nmi_r[1]) acc_src = `VIU_SRC_BRK;
		else if (nmi_r[2]) acc_src = `VIU_SRC_DBG;
		else if (nmi_r[3]) acc_src = `VIU_SRC_WDT;
		acc = (st_r == S_IDLE) && !mem_r.req && cpu_at_boundary && (acc_nmi || win_ok);
	end

	// request bits, status word and trap latches; a set beats any clear
	always_comb begin
		ctl_nxt      = ctl_r;
		ps_nxt       = ps_r;
		wdt_prev_nxt = wdt_msb;
		nmi_nxt      = nmi_r;
		for (int i = 0; i < NSRC; i++) begin
			if (apb_wr && ctl_hit && ctl_src == 5'(i))
				ctl_nxt[i] = pwdata[7:0] & ((i < 3) ? `VIU_CTL_MASK_X : `VIU_CTL_MASK);
			else if (acc && !acc_nmi && acc_src == 5'(i))
				ctl_nxt[i][`VIU_REQ] = 1'b0;
			if (set_evt[i])
				ctl_nxt[i][`VIU_REQ] = 1'b1;
		end
		if (apb_wr && idx == `VIU_IDX_PS)
			ps_nxt = pwdata[15:0];
		if (acc) begin
			ps_nxt[`VIU_PS_IFLAG] = 1'b1;
			nmi_nxt[acc_src[1:0]] = nmi_r[acc_src[1:0]] & ~acc_nmi;
		end
		nmi_nxt = nmi_nxt | {wdt_fall, debug_trap, software_break_trap, zero_div_trap};
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_r      <= '{default: `VIU_CTL_RST};
			ps_r       <= `VIU_PS_RST;
			nmi_r      <= 4'h0;
			wdt_prev_r <= 1'b0;
			prdata_r   <= 32'h0000_0000;
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
		end else begin
			ctl_r      <= ctl_nxt;
			ps_r       <= ps_nxt;
			nmi_r      <= nmi_nxt;
			wdt_prev_r <= wdt_prev_nxt;
			prdata_r   <= prdata_nxt;
			pready_r   <= pready_nxt;
			pslverr_r  <= pslverr_nxt;
		end
	end

	// sequencer: one memory request per state, the next state on mem_ack
	always_comb begin
		st_nxt    = st_r;
		mem_nxt   = mem_r;
		frm_nxt   = frm_r;
		sp_nxt    = sp_r;
		wide_nxt  = wide_r;
		src_nxt   = src_r;
		taken_nxt = 1'b0;
		jpc_nxt   = jpc_r;
		jpg_nxt   = jpg_r;
		if (mem_r.req) begin
			if (mem_ack) begin
				mem_nxt.req = 1'b0;
				case (st_r)
					S_PG: begin
						sp_nxt = sp_r - `VIU_SP_STEP;
						st_nxt = S_PCH;
					end
					S_PCH: begin
						sp_nxt = sp_r - (wide_r ? `VIU_SP_WSTEP : `VIU_SP_STEP);
						st_nxt = wide_r ? S_PSH : S_PCL;
					end
					S_PCL: begin
						sp_nxt = sp_r - `VIU_SP_STEP;
						st_nxt = S_PSH;
					end
					S_PSH: begin
						sp_nxt = sp_r - (wide_r ? `VIU_SP_WSTEP : `VIU_SP_STEP);
						st_nxt = wide_r ? S_VEC : S_PSL;
					end
					S_PSL: begin
						sp_nxt = sp_r - `VIU_SP_STEP;
						st_nxt = S_VEC;
					end
					S_VEC: begin
						jpc_nxt   = mem_rdata;
						jpg_nxt   = `VIU_BANK0;
						taken_nxt = 1'b1;
						st_nxt    = S_IDLE;
					end
					default: st_nxt = S_IDLE;
				endcase
			end
		end else begin
			mem_nxt.req   = 1'b1;
			mem_nxt.we    = 1'b1;
			mem_nxt.word  = 1'b0;
			mem_nxt.addr  = {`VIU_BANK0, sp_r};
			mem_nxt.wdata = {8'h00, frm_r.pg};
			case (st_r)
				S_IDLE: begin
					mem_nxt.req = 1'b0;
					if (acc) begin
						frm_nxt  = '{pg: cpu_ctx.pg, pc: cpu_ctx.pc, ps: ps_r};
						sp_nxt   = cpu_ctx.sp;
						wide_nxt = ~cpu_ctx.sp[0];
						src_nxt  = acc_src;
						st_nxt   = S_PG;
					end
				end
				S_PG: mem_nxt.wdata = {8'h00, frm_r.pg};
				S_PCH: begin
					mem_nxt.word  = wide_r;
					mem_nxt.addr  = {`VIU_BANK0, wide_r ? sp_r - `VIU_SP_STEP : sp_r};
					mem_nxt.wdata = wide_r ? frm_r.pc : {8'h00, frm_r.pc[15:8]};
				end
				S_PCL: mem_nxt.wdata = {8'h00, frm_r.pc[7:0]};
				S_PSH: begin
					mem_nxt.word  = wide_r;
					mem_nxt.addr  = {`VIU_BANK0, wide_r ? sp_r - `VIU_SP_STEP : sp_r};
					mem_nxt.wdata = wide_r ? frm_r.ps : {8'h00, frm_r.ps[15:8]};
				end
				S_PSL: mem_nxt.wdata = {8'h00, frm_r.ps[7:0]};
				S_VEC: begin
					// vector word at the even address, high byte at the odd one
					mem_nxt.we    = 1'b0;
					mem_nxt.word  = 1'b1;
					mem_nxt.addr  = {`VIU_BANK0, vec_of(src_r)};
					mem_nxt.wdata = 16'h0000;
				end
				default: mem_nxt.req = 1'b0;
			endcase
		end
	end

	// reset starts with the reset vector fetch and no stacking
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r    <= S_VEC;
			mem_r   <= '0;
			frm_r   <= '0;
			sp_r    <= 16'h0000;
			wide_r  <= 1'b0;
			src_r   <= `VIU_SRC_RESET;
			taken_r <= 1'b0;
			jpc_r   <= 16'h0000;
			jpg_r   <= `VIU_BANK0;
		end else begin
			st_r    <= st_nxt;
			mem_r   <= mem_nxt;
			frm_r   <= frm_nxt;
			sp_r    <= sp_nxt;
			wide_r  <= wide_nxt;
			src_r   <= src_nxt;
			taken_r <= taken_nxt;
			jpc_r   <= jpc_nxt;
			jpg_r   <= jpg_nxt;
		end
	end

	assign prdata                = prdata_r;
	assign pready                = pready_r;
	assign pslverr               = pslverr_r;
	assign mem                   = mem_r;
	assign vector_taken          = taken_r;
	assign program_counter_reg   = jpc_r;
	assign program_bank_reg      = jpg_r;
	assign stack_ptr             = sp_r;
	assign processor_status_word = ps_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence s_pg_done;
		st_r == S_PG && mem_r.req && mem_ack;
	endsequence

	chk_vector_load: assert property (taken_r |->
		jpg_r == `VIU_BANK0 && jpc_r == $past(mem_rdata)) else $error("bad vector load");
	chk_push_order: assert property (s_pg_done |=> st_r == S_PCH && !mem_r.req ##1
		mem_r.req && mem_r.we) else $error("counter push does not follow bank");
	chk_push_width: assert property (acc |=> wide_r == ~$past(cpu_ctx.sp[0])
		) else $error("push width not from stack pointer parity");
	chk_iflag_mask: assert property ((acc && !acc_nmi) |->
		!ps_r[`VIU_PS_IFLAG] ##1 ps_r[`VIU_PS_IFLAG]) else $error("masked source taken");
	chk_level_gt: assert property ((acc && !acc_nmi) |->
		ctl_r[acc_src[3:0]][`VIU_LVL] > ps_r[`VIU_PS_IPL]) else $error("level not above ipl");
	chk_req_clear: assert property ((acc && !acc_nmi && !apb_wr
		&& !set_evt[acc_src[3:0]]) |=> !ctl_r[$past(acc_src[3:0])][`VIU_REQ])
		else $error("request bit not cleared on acceptance");
	chk_wdt_nmi: assert property ($fell(wdt_msb) |=> nmi_r[3] ##[1:40] vector_taken)
		else $error("watchdog fall lost");
	chk_serial_gate: assert property ((!ctl_r[`VIU_SRC_U0RX][`VIU_REQ] && !serial_async[0]
		&& !apb_wr) |=> !ctl_r[`VIU_SRC_U0RX][`VIU_REQ]) else $error("serial request in sync mode");
	chk_vec_addr: assert property ((st_r == S_VEC && mem_r.req) |->
		!mem_r.we && mem_r.addr[15:0] >= `VIU_VEC_LOW && !mem_r.addr[0])
		else $error("vector fetch outside table");

endmodule // viu_core

// >>> viu_cpu_model.sv
// viu_cpu_model: cpu bus side of the interrupt unit; answers stack pushes
// and vector reads, and logs every completed transfer for the bench.
// assumes: one request at a time, held by the unit until mem_ack.
`timescale 1ns/1ps

module viu_cpu_model import viu_pkg::*; (
	input  wire logic     core_clk,
	input  wire logic     arst_n,
	input  wire viu_mem_s mem,
	input  wire logic     slow,
	output logic          mem_ack,
	output logic [15:0]   mem_rdata
);
	logic [41:0] log_q [0:63];
	int          n_log;
	int          wait_cnt;

	// ack after one or four cycles; read data toggles outside the ack cycle
	// so that a stale sample never matches by luck
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_ack   <= 1'b0;
			mem_rdata <= 16'h0000;
			n_log     <= 0;
			wait_cnt  <= 0;
		end else if (mem.req && !mem_ack && wait_cnt >= (slow ? 3 : 0)) begin
			mem_ack   <= 1'b1;
			mem_rdata <= mem.addr[15:0] ^ 16'hA5A5;
			log_q[n_log[5:0]] <= {mem.we, mem.word, mem.addr,
				mem.we ? (mem.word ? mem.wdata : {8'h00, mem.wdata[7:0]}) : 16'h0000};
			n_log     <= n_log + 1;
			wait_cnt  <= 0;
		end else begin
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_cnt  <= (mem.req && !mem_ack) ? wait_cnt + 1 : 0;
		end
	end
endmodule // viu_cpu_model

// >>> viu_core_tb.sv
// viu_core_tb: self-checking bench for the vectored interrupt unit.
// assumes: apb registers as in viu_regs.svh, cpu bus answered by the model.
`timescale 1ns/1ps
`include "viu_regs.svh"

module viu_core_tb import viu_pkg::*;;
	logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	viu_ctx_s    cpu_ctx;
	viu_evt_s    evt;
	viu_mem_s    mem;
	logic [1:0]  serial_async;
	logic [2:0]  external_request_pin;
	logic        cpu_at_boundary, zero_div_trap, software_break_trap, debug_trap;
	logic        wdt_msb, mem_ack, vector_taken, slow;
	logic [15:0] mem_rdata, program_counter_reg, stack_ptr, processor_status_word;
	logic [15:0] sp_v, pc_v;
	logic [7:0]  program_bank_reg;
	int          failures, samples_checked, n0;

	viu_core #(.NSRC(`VIU_NSRC)) viu_core_i (.core_clk(core_clk), .arst_n(arst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_ctx(cpu_ctx), .cpu_at_boundary(cpu_at_boundary), .evt(evt),
		.serial_async(serial_async), .external_request_pin(external_request_pin),
		.zero_div_trap(zero_div_trap), .software_break_trap(software_break_trap),
		.debug_trap(debug_trap), .wdt_msb(wdt_msb), .mem(mem), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .vector_taken(vector_taken),
		.program_counter_reg(program_counter_reg), .program_bank_reg(program_bank_reg),
		.stack_ptr(stack_ptr), .processor_status_word(processor_status_word));
	viu_cpu_model viu_cpu_model_i (.core_clk(core_clk), .arst_n(arst_n), .mem(mem),
		.slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	// free-running core clock, 40 ns period
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [11:0] ra(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction

	function automatic logic [41:0] ent(input logic we, wd, input logic [15:0] a, d);
		return {we, wd, 8'h00, a, d};
	endfunction

	// one apb transfer; the request holds until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse_evt(input logic [12:0] v);
		evt <= viu_evt_s'(v);
		@(posedge core_clk);
		evt <= '0;
		repeat (10) @(posedge core_clk);
	endtask

	task automatic arm(input logic [15:0] s, p);
		sp_v = s;
		pc_v = p;
		cpu_ctx <= '{pg: 8'h3C, pc: p, sp: s};
		n0 = viu_cpu_model_i.n_log;
	endtask

	task automatic wait_taken();
		repeat (300) begin
			@(posedge core_clk);
			if (vector_taken === 1'b1)
				break;
		end
		check(vector_taken, 1'b1);
	endtask

	// waits for the vector load, then compares the whole stack frame
	task automatic take(input logic [15:0] psv, va);
		logic [41:0] e [$];
		wait_taken();
		e.push_back(ent(1, 0, sp_v, 16'h003C));
		if (!sp_v[0]) begin
			e.push_back(ent(1, 1, sp_v - 16'h0002, pc_v));
			e.push_back(ent(1, 1, sp_v - 16'h0004, psv));
		end else begin
			e.push_back(ent(1, 0, sp_v - 16'h0001, {8'h00, pc_v[15:8]}));
			e.push_back(ent(1, 0, sp_v - 16'h0002, {8'h00, pc_v[7:0]}));
			e.push_back(ent(1, 0, sp_v - 16'h0003, {8'h00, psv[15:8]}));
			e.push_back(ent(1, 0, sp_v - 16'h0004, {8'h00, psv[7:0]}));
		end
		e.push_back(ent(0, 1, va, 16'h0000));
		check(viu_cpu_model_i.n_log - n0, e.size());
		foreach (e[k])
			check(viu_cpu_model_i.log_q[n0 + k], e[k]);
		check({program_bank_reg, program_counter_reg, stack_ptr},
			{8'h00, va ^ 16'hA5A5, sp_v - 16'h0005});
		check(processor_status_word, psv | 16'h0004);
	endtask

	task automatic t_reset();
		n0 = 0;
		wait_taken();
		check(viu_cpu_model_i.log_q[0], ent(0, 1, `VIU_VEC_RESET, 16'h0000));
		check(program_counter_reg, `VIU_VEC_RESET ^ 16'hA5A5);
		apb(1'b0, ra(`VIU_IDX_PS), 32'h0);
		check(rd, 32'h0000_0004);
	endtask

	// level and unused bits, then refused addresses
	task automatic t_regs();
		apb(1'b1, ra(`VIU_IDX_TA0), 32'hFFFF_FFF5);
		apb(1'b0, ra(`VIU_IDX_TA0), 32'h0);
		check(rd, 32'h0000_0005);
		apb(1'b0, ra(8'h10), 32'h0);
		check({err, rd}, {1'b1, 32'h0});
		apb(1'b0, 12'h1D5, 32'h0);
		check(err, 1'b1);
	endtask

	// level not above threshold stays pending; serial gated by its mode
	task automatic t_mask_serial();
		arm(16'h0FFE, 16'h1234);
		apb(1'b1, ra(`VIU_IDX_PS), 32'h0000_0200);
		apb(1'b1, ra(8'h76), 32'h0000_0002);
		pulse_evt(13'h0200);
		apb(1'b0, ra(8'h76), 32'h0);
		check(rd, 32'h0000_000A);
		check(viu_cpu_model_i.n_log - n0, 0);
		apb(1'b1, ra(`VIU_IDX_U0RX), 32'h0000_0007);
		pulse_evt(13'h0008);
		apb(1'b0, ra(`VIU_IDX_U0RX), 32'h0);
		check(rd, 32'h0000_0007);
		serial_async <= 2'b01;
		pulse_evt(13'h0008);
		take(16'h0200, 16'hFFDE);
		apb(1'b0, ra(`VIU_IDX_U0RX), 32'h0);
		check(rd, 32'h0000_0007);
		apb(1'b0, ra(`VIU_IDX_PS), 32'h0);
		check(rd, 32'h0000_0204);
	endtask

	// non-maskables with the disable flag set; break on odd stack and slow bus
	task automatic t_nmi();
		slow <= 1'b1;
		arm(16'h0FFF, 16'hBEEF);
		software_break_trap <= 1'b1;
		@(posedge core_clk);
		software_break_trap <= 1'b0;
		take(16'h0204, `VIU_VEC_BRK);
		slow <= 1'b0;
		arm(16'h0F00, 16'h4321);
		wdt_msb <= 1'b0;
		take(16'h0204, `VIU_VEC_WDT);
	endtask

	// external pin in low-level mode
	task automatic t_pin();
		apb(1'b1, ra(8'h76), 32'h0);
		apb(1'b1, ra(`VIU_IDX_INT0), 32'h0000_0033);
		apb(1'b1, ra(`VIU_IDX_PS), 32'h0);
		arm(16'h0EF1, 16'h5A5A);
		external_request_pin <= 3'b110;
		take(16'h0000, 16'hFFF4);
		external_request_pin <= 3'b111;
	endtask

	// zero-divide trap held off off-boundary, level ties, edge pins; level pins never latch
	task automatic t_more();
		cpu_at_boundary <= 1'b0;
		arm(16'h0E00, 16'h1111);
		zero_div_trap <= 1'b1;
		@(posedge core_clk);
		zero_div_trap <= 1'b0;
		repeat (5) @(posedge core_clk);
		check(viu_cpu_model_i.n_log - n0, 0);
		cpu_at_boundary <= 1'b1;
		take(16'h0004, `VIU_VEC_ZDIV);
		arm(16'h0E00, 16'h2222);
		debug_trap <= 1'b1;
		@(posedge core_clk);
		debug_trap <= 1'b0;
		take(16'h0004, `VIU_VEC_DBG);
		apb(1'b1, ra(8'h7A), 32'h0000_0003);
		apb(1'b1, ra(`VIU_IDX_ADC), 32'h0000_0003);
		pulse_evt(13'h0021);
		arm(16'h0D00, 16'h3333);
		apb(1'b1, ra(`VIU_IDX_PS), 32'h0);
		take(16'h0000, 16'hFFE4);
		arm(16'h0C00, 16'h4444);
		apb(1'b1, ra(`VIU_IDX_PS), 32'h0);
		take(16'h0000, 16'hFFD6);
		apb(1'b1, ra(8'h7E), 32'h0000_0014);
		apb(1'b1, ra(8'h7F), 32'h0000_0004);
		external_request_pin <= 3'b000;
		repeat (3) @(posedge core_clk);
		external_request_pin <= 3'b011;
		apb(1'b0, ra(`VIU_IDX_INT0), 32'h0);
		check(rd, 32'h0000_0033);
		apb(1'b0, ra(8'h7E), 32'h0);
		check(rd, 32'h0000_001C);
		apb(1'b0, ra(8'h7F), 32'h0);
		check(rd, 32'h0000_000C);
		arm(16'h0B00, 16'h5555);
		apb(1'b1, ra(`VIU_IDX_PS), 32'h0);
		take(16'h0000, 16'hFFF2);
		apb(1'b0, ra(8'h7E), 32'h0);
		check(rd, 32'h0000_0014);
		apb(1'b1, ra(8'h7F), 32'h0);
	endtask

	// stall guard
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		finish_test();
	end

	initial begin
		failures = 0;
		samples_checked = 0;
		arst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		cpu_ctx = '0;
		evt = '0;
		serial_async = 2'b00;
		external_request_pin = 3'b111;
		{zero_div_trap, software_break_trap, debug_trap, slow} = '0;
		cpu_at_boundary = 1'b1;
		wdt_msb = 1'b1;
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		t_reset();
		t_regs();
		t_mask_serial();
		t_nmi();
		t_pin();
		t_more();
		finish_test();
	end
endmodule // viu_core_tb
